// File: hw/tlos_pkg.sv
// shared constants, types and register map for the tributary los/oof block
// assumes one 100 MHz clock and a plain strobe register port
package tlos_pkg;

    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int NCH = 3;                       // tributary channels

    // ----------------------------------------------------------------
    // mode encoding (two bits per channel in the mode register)
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        TLOS_DS3 = 2'h0,
        TLOS_E3 = 2'h1,
        TLOS_STS1 = 2'h2
    } tlos_mode_t;

    // ----------------------------------------------------------------
    // los thresholds
    // ----------------------------------------------------------------
    localparam logic [7:0] DS3_ZERO_RUN = 8'hB4;   // 180 zeros declare
    localparam logic [7:0] DS3_WIN_LEN = 8'hB4;    // 180 bit window
    localparam logic [7:0] DS3_ONES_MIN = 8'h3C;   // 60 ones clear
    localparam logic [7:0] E3_ZERO_RUN = 8'h20;    // 32 zeros declare
    localparam logic [7:0] E3_BLK_LEN = 8'h20;     // 32 bit block
    localparam logic [7:0] E3_ONES_MIN = 8'h08;    // 8 ones per block
    localparam logic [2:0] E3_GOOD_BLKS = 3'h4;    // four good blocks
    localparam logic [15:0] STS1_TH_RST = 16'h0010; // threshold reset value

    // ----------------------------------------------------------------
    // register indices (addr is 4 bits)
    // ----------------------------------------------------------------
    localparam logic [3:0] REG_MODE = 4'h0;      // {ch2,ch1,ch0} 2 bits each
    localparam logic [3:0] REG_CFG = 4'h1;       // bit n: data-based clear
    localparam logic [3:0] REG_STATUS = 4'h2;    // live los/oof
    localparam logic [3:0] REG_IRQ_STAT = 4'h3;  // sticky, write one clear
    localparam logic [3:0] REG_IRQ_MASK = 4'h4;  // one enables
    localparam logic [3:0] REG_TH0 = 4'h5;       // sts1 threshold ch0
    localparam int LOS_BIT = 0;                  // status field offsets
    localparam int OOF_BIT = 3;
    localparam logic [5:0] MODE_RST = 6'h00;
    localparam logic [2:0] CFG_RST = 3'h7;

    // per-channel receive sample
    typedef struct packed {
        logic pos;        // positive rail
        logic neg;        // negative rail
        logic valid;      // one bit time
        logic byte_zero;  // sts1 byte boundary with all-zero byte
        logic byte_nz;    // sts1 byte boundary with nonzero byte
        logic oof;        // framer out of frame
    } tlos_rx_t;

endpackage

// File: hw/tlos_top.sv
// los and out-of-frame indication for three receive tributaries
// assumes rails, byte flags and framer oof arrive synchronous to clk
`timescale 1ns/1ns
module tlos_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [2:0] external_signal_loss_in,
    input wire tlos_pkg::tlos_rx_t [2:0] rx_in,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic [2:0] signal_loss_out,
    output logic [2:0] frame_sync_lost_out,
    output logic irq
);

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    logic [5:0] mode_q, mode_d;               // channel modes
    logic [2:0] cfg_q, cfg_d;                 // data clear enables
    logic [5:0] ist_q, ist_d;                 // sticky events
    logic [5:0] imask_q, imask_d;             // interrupt mask
    logic [15:0] th_q [3];                    // sts1 thresholds
    logic [15:0] th_d [3];
    logic [15:0] rdata_q, rdata_d;            // read data
    logic [2:0] los_q;                        // per-channel los
    logic [2:0] oof_q;                        // per-channel oof
    logic [5:0] stat_now;                     // live status
    logic [5:0] stat_prev_q;                  // previous status
    logic [5:0] events;                       // status changes

    // mode decode used by each channel
    function automatic tlos_pkg::tlos_mode_t mode_of(
        input logic [5:0] m, input int ch);
        logic [1:0] f;
        f = m[ch*2 +: 2];
        case (f)
            2'h1: mode_of = tlos_pkg::TLOS_E3;
            2'h2: mode_of = tlos_pkg::TLOS_STS1;
            default: mode_of = tlos_pkg::TLOS_DS3;
        endcase
    endfunction

    assign stat_now = {oof_q, los_q};
    assign events = stat_now ^ stat_prev_q;

    // register next-state: writes, w1c sticky with set winning, reads
    always_comb begin
        mode_d = mode_q;
        cfg_d = cfg_q;
        imask_d = imask_q;
        ist_d = ist_q;
        rdata_d = 16'h0000;
        for (int i = 0; i < 3; i++) begin
            th_d[i] = th_q[i];
        end
        if (reg_wr) begin
            case (reg_addr)
                tlos_pkg::REG_MODE: mode_d = reg_wdata[5:0];
                tlos_pkg::REG_CFG: cfg_d = reg_wdata[2:0];
                tlos_pkg::REG_IRQ_STAT: ist_d = ist_q & ~reg_wdata[5:0];
                tlos_pkg::REG_IRQ_MASK: imask_d = reg_wdata[5:0];
                tlos_pkg::REG_TH0: th_d[0] = reg_wdata;
                tlos_pkg::REG_TH0 + 4'h1: th_d[1] = reg_wdata;
                tlos_pkg::REG_TH0 + 4'h2: th_d[2] = reg_wdata;
                default: ; // unmapped writes ignored
            endcase
        end
        ist_d = ist_d | events; // set wins over clear
        if (reg_rd) begin
            case (reg_addr)
                tlos_pkg::REG_MODE: rdata_d = {10'h000, mode_q};
                tlos_pkg::REG_CFG: rdata_d = {13'h0000, cfg_q};
                tlos_pkg::REG_STATUS: rdata_d = {10'h000, stat_now};
                tlos_pkg::REG_IRQ_STAT: rdata_d = {10'h000, ist_q};
                tlos_pkg::REG_IRQ_MASK: rdata_d = {10'h000, imask_q};
                tlos_pkg::REG_TH0: rdata_d = th_q[0];
                tlos_pkg::REG_TH0 + 4'h1: rdata_d = th_q[1];
                tlos_pkg::REG_TH0 + 4'h2: rdata_d = th_q[2];
                default: rdata_d = 16'h0000; // unmapped reads zero
            endcase
        end
    end

    // register state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_q <= tlos_pkg::MODE_RST;
            cfg_q <= tlos_pkg::CFG_RST;
            ist_q <= 6'h00;
            imask_q <= 6'h00;
            rdata_q <= 16'h0000;
            stat_prev_q <= 6'h00;
            for (int i = 0; i < 3; i++) begin
                th_q[i] <= tlos_pkg::STS1_TH_RST;
            end
        end else if (clk_en) begin
            mode_q <= mode_d;
            cfg_q <= cfg_d;
            ist_q <= ist_d;
            imask_q <= imask_d;
            rdata_q <= rdata_d;
            stat_prev_q <= stat_now;
            for (int i = 0; i < 3; i++) begin
                th_q[i] <= th_d[i];
            end
        end
    end

    assign reg_rdata = rdata_q;
    assign irq = |(ist_q & imask_q);
    assign signal_loss_out = los_q;
    assign frame_sync_lost_out = oof_q;

    // ----------------------------------------------------------------
    // per-channel detection
    // ----------------------------------------------------------------
    for (genvar c = 0; c < 3; c++) begin : g_ch
        typedef enum {ST_OK, ST_LOS} st_t;
        st_t st_q, st_d;                     // los state
        logic [1:0] sync_q, sync_d;          // external loss synchroniser
        logic [15:0] zrun_q, zrun_d;         // zero run (bits or bytes)
        logic [7:0] wcnt_q, wcnt_d;          // window bit position
        logic [7:0] ones_q, ones_d;          // ones inside window
        logic [2:0] good_q, good_d;          // good e3 blocks in a row
        logic oof_d;                         // next oof
        logic mark;                          // nonzero bit seen
        logic ext;                           // synced external loss
        logic data_clear;                    // data-based clear met
        tlos_pkg::tlos_mode_t md;            // this channel's mode
        tlos_pkg::tlos_rx_t rx;

        assign rx = rx_in[c];
        assign md = mode_of(mode_q, c);
        assign ext = sync_q[1];
        assign mark = rx.pos | rx.neg;

        // next state: counters, declare and clear decisions
        always_comb begin
            sync_d = {sync_q[0], external_signal_loss_in[c]};
            st_d = st_q;
            zrun_d = zrun_q;
            wcnt_d = wcnt_q;
            ones_d = ones_q;
            good_d = good_q;
            data_clear = 1'b0;
            oof_d = rx.oof;
            if (md == tlos_pkg::TLOS_STS1) begin
                // external input is not looked at here
                if (rx.byte_zero && zrun_q != 16'hFFFF) begin
                    zrun_d = zrun_q + 16'h0001;
                end else if (rx.byte_nz) begin
                    zrun_d = 16'h0000;
                end
                if (zrun_d >= th_q[c]) begin
                    st_d = ST_LOS;
                end else begin
                    st_d = ST_OK;
                end
            end else if (rx.valid) begin
                // zero run for declare
                if (mark) begin
                    zrun_d = 16'h0000;
                end else if (zrun_q != 16'hFFFF) begin
                    zrun_d = zrun_q + 16'h0001;
                end
                // ones window for clear
                ones_d = ones_q + {7'h00, mark};
                wcnt_d = wcnt_q + 8'h01;
                if (md == tlos_pkg::TLOS_DS3) begin
                    // at or past the end: a window left long by a mode
                    // change is closed at once instead of wrapping
                    if (wcnt_d >= tlos_pkg::DS3_WIN_LEN) begin
                        data_clear = ones_d >= tlos_pkg::DS3_ONES_MIN;
                        wcnt_d = 8'h00;
                        ones_d = 8'h00;
                    end
                    if (zrun_d >= {8'h00, tlos_pkg::DS3_ZERO_RUN}) begin
                        st_d = ST_LOS;
                    end
                end else begin
                    // a block left long by a change from ds3 closes here
                    if (wcnt_d >= tlos_pkg::E3_BLK_LEN) begin
                        if (ones_d >= tlos_pkg::E3_ONES_MIN) begin
                            if (good_q != tlos_pkg::E3_GOOD_BLKS) begin
                                good_d = good_q + 3'h1;
                            end
                        end else begin
                            good_d = 3'h0;
                        end
                        data_clear = good_d == tlos_pkg::E3_GOOD_BLKS;
                        wcnt_d = 8'h00;
                        ones_d = 8'h00;
                    end
                    if (zrun_d >= {8'h00, tlos_pkg::E3_ZERO_RUN}) begin
                        st_d = ST_LOS;
                    end
                end
                // clear only with external low and, when the cfg bit is set, data good
                if (st_q == ST_LOS && !ext &&
                    (data_clear || !cfg_q[c])) begin
                    st_d = ST_OK;
                end
            end else if (st_q == ST_LOS && !ext && !cfg_q[c]) begin
                st_d = ST_OK;
            end
            if (md != tlos_pkg::TLOS_STS1 && ext) begin
                st_d = ST_LOS;
            end
        end

        // channel state
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                st_q <= ST_OK;
                sync_q <= 2'h0;
                zrun_q <= 16'h0000;
                wcnt_q <= 8'h00;
                ones_q <= 8'h00;
                good_q <= 3'h0;
                oof_q[c] <= 1'b0;
                los_q[c] <= 1'b0;
            end else if (clk_en) begin
                st_q <= st_d;
                sync_q <= sync_d;
                zrun_q <= zrun_d;
                wcnt_q <= wcnt_d;
                ones_q <= ones_d;
                good_q <= good_d;
                oof_q[c] <= oof_d;
                los_q[c] <= (st_d == ST_LOS);
            end
        end
    end

endmodule

// File: tb/tlos_properties.sv
// port checker for the tributary los/oof block
// assumes it sees only the ports of tlos_top, bound below
`timescale 1ns/1ns
module tlos_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [2:0] external_signal_loss_in,
    input wire tlos_pkg::tlos_rx_t [2:0] rx_in,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [2:0] signal_loss_out,
    input wire logic [2:0] frame_sync_lost_out,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [5:0] mode_q; // copy of the mode register
    logic [5:0] mask_q; // copy of the interrupt mask
    logic [7:0] zrun_q; // zero bits in a row, channel 0
    logic z0; // a zero bit on channel 0
    assign z0 = rx_in[0].valid && !rx_in[0].pos && !rx_in[0].neg;
    // mirrors of software state and the zero run
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_q <= 6'h00;
            mask_q <= 6'h00;
            zrun_q <= 8'h00;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == 4'h0) mode_q <= reg_wdata[5:0];
            if (reg_wr && reg_addr == 4'h4) mask_q <= reg_wdata[5:0];
            if (rx_in[0].valid) begin
                zrun_q <= z0 ? zrun_q + {7'h00, zrun_q != 8'hFF} : 8'h00;
            end
        end
    end
    oof_follow_a: assert property (
        clk_en |=> frame_sync_lost_out == {$past(rx_in[2].oof),
        $past(rx_in[1].oof), $past(rx_in[0].oof)})
        else $error("oof output does not follow framer");
    ds3_declare_a: assert property (
        clk_en && mode_q[1:0] == 2'h0 && z0 && zrun_q == 8'hB3
        |=> signal_loss_out[0]) else $error("ds3 los missing");
    e3_declare_a: assert property (
        clk_en && mode_q[1:0] == 2'h1 && z0 && zrun_q == 8'h1F
        |=> signal_loss_out[0]) else $error("e3 los missing");
    ext_force_a: assert property (
        (clk_en && external_signal_loss_in[0] && mode_q[1:0] != 2'h2)[*3]
        |=> signal_loss_out[0]) else $error("external loss not forced");
    clear_ext_a: assert property (
        $fell(signal_loss_out[0]) && $past(mode_q[1:0]) != 2'h2 &&
        $past(mode_q[1:0], 2) != 2'h2
        |-> !$past(external_signal_loss_in[0], 3))
        else $error("los cleared while external loss high");
    sts1_ignore_a: assert property (
        $rose(signal_loss_out[1]) && $past(mode_q[3:2]) == 2'h2 &&
        $past(mode_q[3:2], 2) == 2'h2 |-> $past(rx_in[1].byte_zero) ||
        $past(rx_in[1].byte_zero, 2) || $past(reg_wr) || $past(reg_wr, 2))
        else $error("sts1 los rose without zero byte");
    irq_mask_a: assert property (
        mask_q == 6'h00 |-> !irq) else $error("irq with mask clear");
    rdata_idle_a: assert property (
        clk_en && !reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside read slot");
    cover property (signal_loss_out[0] && mode_q[1:0] == 2'h0);
    cover property ($fell(signal_loss_out[0]) && mode_q[1:0] == 2'h1);
    cover property (irq);
endmodule
bind tlos_top tlos_properties chk_u (.clk(clk), .rst_n(rst_n),
    .clk_en(clk_en), .external_signal_loss_in(external_signal_loss_in),
    .rx_in(rx_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .signal_loss_out(signal_loss_out),
    .frame_sync_lost_out(frame_sync_lost_out), .irq(irq));

// File: tb/tlos_liu_model.sv
// line interface model: loss flag, rails, byte flags and framer oof
// assumes bench commands; one bit every second clock
`timescale 1ns/1ns
module tlos_liu_model (
    input wire logic clk,
    input wire logic [2:0] los_cmd,
    input wire logic [2:0] mark_cmd,
    input wire logic [2:0] bz_cmd,
    input wire logic [2:0] oof_cmd,
    output logic [2:0] ext_loss = 3'h0,
    output tlos_pkg::tlos_rx_t [2:0] rx = '0
);
    logic ph_q = 1'b0; // high while a bit is presented (valid high)
    logic [2:0] pol_q = 3'h0; // marks alternate polarity
    // between bits both rails are driven high, not the last bit
    always @(posedge clk) begin
        ph_q <= !ph_q;
        ext_loss <= los_cmd;
        for (int c = 0; c < 3; c++) begin
            rx[c].valid <= !ph_q;
            rx[c].pos <= ph_q || (mark_cmd[c] && !pol_q[c]);
            rx[c].neg <= ph_q || (mark_cmd[c] && pol_q[c]);
            rx[c].byte_zero <= !ph_q && bz_cmd[c];
            rx[c].byte_nz <= !ph_q && !bz_cmd[c];
            rx[c].oof <= oof_cmd[c];
            if (!ph_q && mark_cmd[c]) pol_q[c] <= !pol_q[c];
        end
    end
endmodule

// File: tb/testbench.sv
// bench for the tributary los/oof block
// assumes the line model and the bound property checker
`timescale 1ns/1ns
module testbench;
    logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, irq;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic [2:0] los_cmd = 3'h0, mark_cmd = 3'h7, bz_cmd = 3'h0;
    logic [2:0] oof_cmd = 3'h0, ext, los, oof;
    tlos_pkg::tlos_rx_t [2:0] rx;
    int errors = 0, tests_run = 0;
    initial forever #5 clk = !clk;
    tlos_liu_model liu_u (.clk(clk), .los_cmd(los_cmd), .mark_cmd(mark_cmd),
        .bz_cmd(bz_cmd), .oof_cmd(oof_cmd), .ext_loss(ext), .rx(rx));
    tlos_top dut_u (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
        .external_signal_loss_in(ext), .rx_in(rx), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .signal_loss_out(los),
        .frame_sync_lost_out(oof), .irq(irq));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic bits(input int n);
        repeat (2 * n) @(posedge clk);
        #1;
    endtask
    task automatic finish_test();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        finish_test();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(4'h0, 16'h0000);
        rd(4'h1, 16'h0007);
        rd(4'h4, 16'h0000);
        rd(4'h7, 16'h0010);
        rd(4'hF, 16'h0000);
        $display("test reset values done");
        @(posedge clk) mark_cmd <= 3'h6;
        bits(175);
        chk({13'h0000, los}, 16'h0000);
        bits(10);
        chk({13'h0000, los}, 16'h0001);
        @(posedge clk) mark_cmd <= 3'h7;
        bits(20);
        chk({13'h0000, los}, 16'h0001);
        bits(380);
        chk({13'h0000, los}, 16'h0000);
        $display("test ds3 done");
        wr(4'h0, 16'h0001);
        @(posedge clk) mark_cmd <= 3'h6;
        bits(28);
        chk({13'h0000, los}, 16'h0000);
        bits(8);
        chk({13'h0000, los}, 16'h0001);
        @(posedge clk) mark_cmd <= 3'h7;
        bits(60);
        chk({13'h0000, los}, 16'h0001);
        bits(110);
        chk({13'h0000, los}, 16'h0000);
        @(posedge clk) los_cmd <= 3'h1;
        bits(50);
        chk({13'h0000, los}, 16'h0001);
        @(posedge clk) los_cmd <= 3'h0;
        bits(200);
        chk({13'h0000, los}, 16'h0000);
        wr(4'h1, 16'h0006);
        @(posedge clk) los_cmd <= 3'h1;
        bits(10);
        chk({13'h0000, los}, 16'h0001);
        @(posedge clk) los_cmd <= 3'h0;
        bits(4);
        chk({13'h0000, los}, 16'h0000);
        wr(4'h1, 16'h0007);
        $display("test e3 done");
        wr(4'h0, 16'h0009);
        wr(4'h6, 16'h0004);
        @(posedge clk) los_cmd <= 3'h2;
        bits(10);
        chk({13'h0000, los}, 16'h0000);
        @(posedge clk) bz_cmd <= 3'h2;
        bits(2);
        chk({13'h0000, los}, 16'h0000);
        bits(10);
        chk({13'h0000, los}, 16'h0002);
        @(posedge clk) bz_cmd <= 3'h0;
        bits(3);
        chk({13'h0000, los}, 16'h0000);
        $display("test sts1 done");
        @(posedge clk) los_cmd <= 3'h0;
        @(posedge clk) oof_cmd <= 3'h4;
        bits(2);
        chk({13'h0000, oof}, 16'h0004);
        rd(4'h2, 16'h0020);
        @(posedge clk) oof_cmd <= 3'h0;
        bits(2);
        chk({13'h0000, oof}, 16'h0000);
        $display("test oof done");
        chk({15'h0000, irq}, 16'h0000);
        wr(4'h4, 16'h003F);
        chk({15'h0000, irq}, 16'h0001);
        wr(4'h3, 16'h003F);
        rd(4'h3, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        @(posedge clk) oof_cmd <= 3'h1;
        bits(2);
        chk({15'h0000, irq}, 16'h0001);
        rd(4'h3, 16'h0008);
        wr(4'h4, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        // clock enable low must freeze the oof output
        @(posedge clk) begin
            clk_en <= 1'b0;
            oof_cmd <= 3'h0;
        end
        bits(3);
        chk({13'h0000, oof}, 16'h0001);
        @(posedge clk) clk_en <= 1'b1;
        bits(1);
        chk({13'h0000, oof}, 16'h0000);
        $display("test interrupt done");
        finish_test();
    end
endmodule
